// ### verilog/cls_map.vh
// Register offsets, reset values and timing constants of the cold load supervisor.
// Behaviour
// RL1: Sample blocking once per program cycle.
// RL2: Unblocked pick-up asserts active, timing continues.
// RL3: Blocked pick-up asserts blocked, nothing more.
// RL4: Late blocking releases active like pick-up reset.
// RL5: Blocking source must lead delay by 5 ms.
// RL6: Activate after low persists start delay.
// RL7: Max-duration timer limits high-current time.
// RL8: Minimum hold time, also reclaim window.
// RL9: High starts max timer; fallback ends start-up.
// RL10: Nonzero hold extends active after start-up.
// RL11: Zero start delay activates immediately.
// RL12: Overcurrent releases active immediately.
// RL13: High until max expiry releases active.
// RL14: No inrush during hold releases active.
// RL15: Inrush in hold runs max timer.
// RL16: Maskable ON/OFF time-stamped status events.
// RL17: Clearable activation and blocked counters.
// RL18: Circular log of last twelve records.
// RL19: Fixed 97 percent reset ratio.
// RL20: Low needs every phase below low threshold.
// RL21: High needs every phase above high threshold.
// RL22: Timers advance one 5 ms tick.
`ifndef CLS_MAP_VH
`define CLS_MAP_VH
`define CLS_CLK_NS 50
`define CLS_TICK_NS 5000000
`define CLS_TICK_MS 32'h00000005
`define CLS_RATIO_NUM 7'h61
`define CLS_RATIO_DEN 7'h64
`define CLS_REG_CTRL 8'h00
`define CLS_REG_LOW 8'h04
`define CLS_REG_HIGH 8'h08
`define CLS_REG_OVER 8'h0C
`define CLS_REG_START 8'h10
`define CLS_REG_MAX 8'h14
`define CLS_REG_MIN 8'h18
`define CLS_REG_EMASK 8'h1C
`define CLS_REG_STATUS 8'h20
`define CLS_REG_ACTCNT 8'h24
`define CLS_REG_BLKCNT 8'h28
`define CLS_REG_LOGSEL 8'h2C
`define CLS_REG_LOGDAT 8'h30
`define CLS_REG_GROUP 8'h34
`define CLS_REG_TIME 8'h38
`define CLS_CTRL_CLR_ACT 0
`define CLS_CTRL_CLR_BLK 1
`define CLS_RST_LOW 16'h0014
`define CLS_RST_HIGH 16'h0078
`define CLS_RST_OVER 16'h00C8
`define CLS_RST_START 19'h007D0
`define CLS_RST_MAX 19'h01770
`define CLS_RST_MIN 19'h00008
`define CLS_RST_EMASK 12'hFFF
`define CLS_RST_GROUP 3'h0
`define CLS_EV_LOW 0
`define CLS_EV_HIGH 1
`define CLS_EV_NORMAL 2
`define CLS_EV_OVER 3
`define CLS_EV_ACT 4
`define CLS_EV_BLOCK 5
`endif

// ### verilog/cls_event_log.v
// Circular record store holding the most recent activation and status records.
`timescale 1ns/1ps
`default_nettype none
module cls_event_log #(
    parameter DEPTH = 12,
    parameter WORDS = 10
) (
    input  wire                  clock,
    input  wire                  rst_n,
    input  wire                  wr_en,
    input  wire [WORDS*32-1:0]   rec,
    input  wire [3:0]            sel_entry,
    input  wire [3:0]            sel_word,
    output reg  [31:0]           rd_data,
    output wire [3:0]            fill
);
    reg [31:0] mem [0:DEPTH*WORDS-1];
    reg [3:0]  ptr_q;
    reg [3:0]  fill_q;
    reg [4:0]  idx;
    integer    k;

    assign fill = fill_q;

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ptr_q  <= 4'h0;
            fill_q <= 4'h0;
        end else if (wr_en) begin // RL18
            ptr_q <= (ptr_q == DEPTH - 1) ? 4'h0 : ptr_q + 4'h1;
            if (fill_q != DEPTH)
                fill_q <= fill_q + 4'h1;
        end
    end

    // The array has no reset so it maps onto plain memory; fill hides stale entries.
    always @(posedge clock) begin
        if (wr_en) begin
            for (k = 0; k < WORDS; k = k + 1)
                mem[ptr_q * WORDS + k] <= rec[k*32 +: 32];
        end
    end

    // Entry zero is the newest record.
    always @* begin
        idx = {1'b0, ptr_q} + DEPTH[4:0] - 5'h01 - {1'b0, sel_entry};
        if (idx >= DEPTH[4:0])
            idx = idx - DEPTH[4:0];
        if (sel_entry < fill_q && sel_word < WORDS)
            rd_data = mem[idx * WORDS + sel_word];
        else
            rd_data = 32'h00000000;
    end
endmodule
`default_nettype wire

// ### verilog/cls_supervisor.v
// Cold load supervisor: comparators, program-cycle timers, events, counters and registers.
//
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "cls_map.vh"
module cls_supervisor #(
    parameter TW          = 19,
    parameter TICK_CYCLES = `CLS_TICK_NS / `CLS_CLK_NS
) (
    input  wire         clock,
    input  wire         rst_n,
    input  wire [15:0]  i_l1,
    input  wire [15:0]  i_l2,
    input  wire [15:0]  i_l3,
    input  wire         block_in,
    input  wire [7:0]   addr,
    input  wire [31:0]  wdata,
    input  wire         wr,
    input  wire         rd,
    output wire [31:0]  rdata,
    output wire         cold_load_active,
    output wire         blocked,
    output wire         evt_valid,
    output wire [2:0]   evt_id,
    output wire         evt_on,
    output wire [31:0]  evt_time
);
    localparam S_IDLE = 3'h0;
    localparam S_WAIT = 3'h1;
    localparam S_MIN  = 3'h2;
    localparam S_HIGH = 3'h3;
    localparam S_HOLD = 3'h4;
    localparam S_BLK  = 3'h5;

    reg [16:0]   tick_cnt_q;
    reg          tick_q;
    reg          step_q;
    reg          blk_s1_q;
    reg          blk_s2_q;
    reg          blk_q;
    reg [31:0]   ms_q;
    reg [2:0]    ab_low_q;
    reg [2:0]    ab_high_q;
    reg [2:0]    ab_over_q;
    reg [2:0]    st_q;
    reg [TW-1:0] start_delay_q;
    reg [TW-1:0] max_high_duration_q;
    reg [TW-1:0] minimum_hold_time_q;
    reg [TW-1:0] act_time_q;
    reg          act_q;
    reg          blkd_q;
    reg          act_inc_q;
    reg          blk_inc_q;
    reg [15:0]   low_thr_q;
    reg [15:0]   high_thr_q;
    reg [15:0]   over_thr_q;
    reg [TW-1:0] start_q;
    reg [TW-1:0] max_q;
    reg [TW-1:0] min_q;
    reg [11:0]   emask_q;
    reg [2:0]    group_q;
    reg [7:0]    log_sel_q;
    reg [15:0]   act_cnt_q;
    reg [15:0]   blk_cnt_q;
    reg [5:0]    prev_bits_q;
    reg [11:0]   pend_q;
    reg          evt_valid_q;
    reg [2:0]    evt_id_q;
    reg          evt_on_q;
    reg [31:0]   evt_time_q;
    reg [31:0]   rdata_q;
    reg [11:0]   grant;
    reg [2:0]    g_id;
    reg          g_on;
    reg [31:0]   rd_val;
    integer      n;

    wire [47:0]  cur_all = {i_l3, i_l2, i_l1};
    wire         low = ~|ab_low_q; // RL20
    wire         high = &ab_high_q; // RL21
    wire         over_any = |ab_over_q;
    wire         normal = ~low & ~high;
    wire [5:0]   st_bits = {blkd_q, act_q, over_any, normal, high, low};
    wire [5:0]   chg = st_bits ^ prev_bits_q;
    wire [11:0]  new_ev = {chg & ~st_bits & emask_q[11:6], chg & st_bits & emask_q[5:0]};
    wire         clr_act = wr && addr == `CLS_REG_CTRL && wdata[`CLS_CTRL_CLR_ACT];
    wire         clr_blk = wr && addr == `CLS_REG_CTRL && wdata[`CLS_CTRL_CLR_BLK];
    wire [TW-1:0] to_act = (st_q == S_WAIT) ? start_q - start_delay_q : {TW{1'b0}};
    wire [31:0]  log_word;
    wire [3:0]   log_fill;
    wire         log_wr = |grant[5:0];
    wire [319:0] rec;

    assign rdata = rdata_q;
    assign cold_load_active = act_q;
    assign blocked = blkd_q;
    assign evt_valid = evt_valid_q;
    assign evt_id = evt_id_q;
    assign evt_on = evt_on_q;
    assign evt_time = evt_time_q;

    // Exceeds threshold, or keeps exceeding until it drops under 97 percent of it.
    function hyst;
        input [15:0] cur;
        input [15:0] thr;
        input        prev;
        reg   [22:0] c;
        reg   [22:0] t;
        begin
            c = cur * `CLS_RATIO_DEN;
            t = thr * `CLS_RATIO_NUM;
            hyst = (cur > thr) || (prev && (c > t));
        end
    endfunction

    // Program cycle timebase; one tick per 5 ms step.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt_q <= 17'h00000;
            tick_q     <= 1'b0;
            step_q     <= 1'b0;
            ms_q       <= 32'h00000000;
        end else begin
            tick_q <= (tick_cnt_q == TICK_CYCLES - 1); // RL22
            tick_cnt_q <= (tick_cnt_q == TICK_CYCLES - 1) ? 17'h00000 : tick_cnt_q + 17'h00001;
            step_q <= tick_q;
            if (tick_q)
                ms_q <= ms_q + `CLS_TICK_MS;
        end
    end

    // The blocking pin is synchronised, then frozen for the whole program cycle.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            blk_s1_q <= 1'b0;
            blk_s2_q <= 1'b0;
            blk_q    <= 1'b0;
        end else begin
            blk_s1_q <= block_in;
            blk_s2_q <= blk_s1_q;
            if (tick_q)
                blk_q <= blk_s2_q; // RL1
        end
    end

    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : g_phase
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    ab_low_q[p]  <= 1'b1;
                    ab_high_q[p] <= 1'b0;
                    ab_over_q[p] <= 1'b0;
                end else if (tick_q) begin // RL19
                    ab_low_q[p]  <= hyst(cur_all[p*16 +: 16], low_thr_q, ab_low_q[p]);
                    ab_high_q[p] <= hyst(cur_all[p*16 +: 16], high_thr_q, ab_high_q[p]);
                    ab_over_q[p] <= hyst(cur_all[p*16 +: 16], over_thr_q, ab_over_q[p]);
                end
            end
        end
    endgenerate

    // Operating sequence, evaluated once per program cycle.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= S_IDLE;
            start_delay_q     <= {TW{1'b0}};
            max_high_duration_q     <= {TW{1'b0}};
            minimum_hold_time_q     <= {TW{1'b0}};
            act_time_q <= {TW{1'b0}};
            act_q      <= 1'b0;
            blkd_q     <= 1'b0;
            act_inc_q  <= 1'b0;
            blk_inc_q  <= 1'b0;
        end else begin
            act_inc_q <= 1'b0;
            blk_inc_q <= 1'b0;
            if (step_q) begin
                if (act_q)
                    act_time_q <= act_time_q + 1'b1;
                case (st_q)
                S_IDLE, S_WAIT: begin
                    if (!low) begin
                        st_q <= S_IDLE;
                    end else if (st_q == S_IDLE && start_q != {TW{1'b0}}) begin
                        st_q   <= S_WAIT; // RL6
                        start_delay_q <= {TW{1'b0}};
                    end else if (st_q == S_WAIT && start_delay_q + 1'b1 < start_q) begin
                        start_delay_q <= start_delay_q + 1'b1; // RL6
                    end else if (blk_q) begin
                        st_q      <= S_BLK; // RL3
                        blkd_q    <= 1'b1;
                        blk_inc_q <= 1'b1;
                    end else begin
                        st_q       <= S_MIN; // RL2 RL11
                        act_q      <= 1'b1;
                        act_inc_q  <= 1'b1;
                        minimum_hold_time_q     <= {TW{1'b0}};
                        max_high_duration_q     <= {TW{1'b0}};
                        act_time_q <= {TW{1'b0}};
                    end
                end
                S_BLK: begin
                    if (!low) begin
                        st_q   <= S_IDLE;
                        blkd_q <= 1'b0;
                    end
                end
                default: begin
                    minimum_hold_time_q <= minimum_hold_time_q + 1'b1; // RL8
                    if (blk_q || over_any) begin
                        st_q  <= S_IDLE; // RL4 RL12
                        act_q <= 1'b0;
                    end else if (st_q == S_HIGH) begin
                        max_high_duration_q <= max_high_duration_q + 1'b1; // RL7
                        if (max_high_duration_q + 1'b1 >= max_q) begin
                            st_q  <= S_IDLE; // RL13
                            act_q <= 1'b0;
                        end else if (!high) begin
                            st_q <= S_HOLD; // RL9 RL10
                        end
                    end else if (high) begin
                        st_q <= S_HIGH; // RL15
                        if (st_q == S_MIN)
                            max_high_duration_q <= {TW{1'b0}}; // RL9
                    end else if (minimum_hold_time_q + 1'b1 >= min_q) begin
                        st_q  <= S_IDLE; // RL14 RL10
                        act_q <= 1'b0;
                    end
                end
                endcase
            end
        end
    end

    // Counters: an increment in the cycle of a clear survives as one.
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            act_cnt_q <= 16'h0000;
            blk_cnt_q <= 16'h0000;
        end else begin
            if (act_inc_q)
                act_cnt_q <= clr_act ? 16'h0001 : act_cnt_q + 16'h0001; // RL17
            else if (clr_act)
                act_cnt_q <= 16'h0000;
            if (blk_inc_q)
                blk_cnt_q <= clr_blk ? 16'h0001 : blk_cnt_q + 16'h0001; // RL17
            else if (clr_blk)
                blk_cnt_q <= 16'h0000;
        end
    end

    // Lowest pending event leaves first; ON events occupy the low half.
    always @* begin
        grant = pend_q & (~pend_q + 12'h001);
        g_id  = 3'h0;
        g_on  = 1'b1;
        for (n = 11; n >= 0; n = n - 1) begin
            if (grant[n]) begin
                g_id = (n > 5) ? n[2:0] - 3'h6 : n[2:0];
                g_on = (n < 6);
            end
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_bits_q <= 6'h04;
            pend_q      <= 12'h000;
            evt_valid_q <= 1'b0;
            evt_id_q    <= 3'h0;
            evt_on_q    <= 1'b0;
            evt_time_q  <= 32'h00000000;
        end else begin
            prev_bits_q <= st_bits;
            pend_q      <= (pend_q & ~grant) | new_ev; // RL16
            evt_valid_q <= |grant;
            if (|grant) begin
                evt_id_q   <= g_id; // RL16
                evt_on_q   <= g_on;
                evt_time_q <= ms_q;
            end
        end
    end

    assign rec = {29'h0, group_q, {(32-TW){1'b0}}, minimum_hold_time_q, {(32-TW){1'b0}}, max_high_duration_q,
                  {(32-TW){1'b0}}, act_time_q, {(32-TW){1'b0}}, to_act,
                  16'h0, i_l3, 16'h0, i_l2, 16'h0, i_l1, 29'h0, g_id, ms_q};

    cls_event_log #(
        .DEPTH (12),
        .WORDS (10)
    ) u_log (
        .clock     (clock),
        .rst_n     (rst_n),
        .wr_en     (log_wr), // RL18
        .rec       (rec),
        .sel_entry (log_sel_q[7:4]),
        .sel_word  (log_sel_q[3:0]),
        .rd_data   (log_word),
        .fill      (log_fill)
    );

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            low_thr_q  <= `CLS_RST_LOW;
            high_thr_q <= `CLS_RST_HIGH;
            over_thr_q <= `CLS_RST_OVER;
            start_q    <= `CLS_RST_START;
            max_q      <= `CLS_RST_MAX;
            min_q      <= `CLS_RST_MIN;
            emask_q    <= `CLS_RST_EMASK;
            group_q    <= `CLS_RST_GROUP;
            log_sel_q  <= 8'h00;
        end else if (wr) begin
            if (addr == `CLS_REG_LOW)
                low_thr_q <= wdata[15:0];
            else if (addr == `CLS_REG_HIGH)
                high_thr_q <= wdata[15:0];
            else if (addr == `CLS_REG_OVER)
                over_thr_q <= wdata[15:0];
            else if (addr == `CLS_REG_START)
                start_q <= wdata[TW-1:0];
            else if (addr == `CLS_REG_MAX)
                max_q <= wdata[TW-1:0];
            else if (addr == `CLS_REG_MIN)
                min_q <= wdata[TW-1:0];
            else if (addr == `CLS_REG_EMASK)
                emask_q <= wdata[11:0];
            else if (addr == `CLS_REG_GROUP)
                group_q <= wdata[2:0];
            else if (addr == `CLS_REG_LOGSEL)
                log_sel_q <= wdata[7:0];
        end
    end

    always @* begin
        rd_val = 32'h00000000;
        if (addr == `CLS_REG_LOW)
            rd_val[15:0] = low_thr_q;
        else if (addr == `CLS_REG_HIGH)
            rd_val[15:0] = high_thr_q;
        else if (addr == `CLS_REG_OVER)
            rd_val[15:0] = over_thr_q;
        else if (addr == `CLS_REG_START)
            rd_val[TW-1:0] = start_q;
        else if (addr == `CLS_REG_MAX)
            rd_val[TW-1:0] = max_q;
        else if (addr == `CLS_REG_MIN)
            rd_val[TW-1:0] = min_q;
        else if (addr == `CLS_REG_EMASK)
            rd_val[11:0] = emask_q;
        else if (addr == `CLS_REG_STATUS)
            rd_val[15:0] = {log_fill, 3'h0, st_q, st_bits};
        else if (addr == `CLS_REG_ACTCNT)
            rd_val[15:0] = act_cnt_q;
        else if (addr == `CLS_REG_BLKCNT)
            rd_val[15:0] = blk_cnt_q;
        else if (addr == `CLS_REG_LOGSEL)
            rd_val[7:0] = log_sel_q;
        else if (addr == `CLS_REG_LOGDAT)
            rd_val = log_word;
        else if (addr == `CLS_REG_GROUP)
            rd_val[2:0] = group_q;
        else if (addr == `CLS_REG_TIME)
            rd_val = ms_q;
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rd ? rd_val : 32'h00000000;
    end
endmodule
`default_nettype wire

// ### verification/cls_feed.sv
// Phase current source and blocking matrix model for the supervisor inputs.
`timescale 1ns/1ps
`default_nettype none
module cls_feed (
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [1:0]  lvl,
    input  wire logic        blk,
    output var  logic [15:0] i_l1,
    output var  logic [15:0] i_l2,
    output var  logic [15:0] i_l3,
    output var  logic        block_in
);
    // Phases differ, but only at level three do they fall on both sides of a threshold: L1 alone is above overcurrent.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {i_l1, i_l2, i_l3} <= {16'h0050, 16'h005A, 16'h0046};
            block_in <= 1'b0;
        end else begin
            block_in <= blk;
            case (lvl)
                2'h0: {i_l1, i_l2, i_l3} <= {16'h000A, 16'h000C, 16'h0008};
                2'h1: {i_l1, i_l2, i_l3} <= {16'h0050, 16'h005A, 16'h0046};
                2'h2: {i_l1, i_l2, i_l3} <= {16'h0096, 16'h00A0, 16'h008C};
                default: {i_l1, i_l2, i_l3} <= {16'h00FA, 16'h0096, 16'h0096};
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verification/cls_supervisor_properties.sv
// Port-level checks of the cold load supervisor.
`timescale 1ns/1ps
`default_nettype none
module cls_supervisor_properties #(
    parameter TW          = 19,
    parameter TICK_CYCLES = 20
) (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [15:0] i_l1,
    input wire logic [15:0] i_l2,
    input wire logic [15:0] i_l3,
    input wire logic        block_in,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        cold_load_active,
    input wire logic        blocked,
    input wire logic        evt_valid,
    input wire logic [2:0]  evt_id,
    input wire logic        evt_on,
    input wire logic [31:0] evt_time
);
    localparam int REACT = TICK_CYCLES + 4;
    // Blocking may just miss one tick in its synchroniser, so two ticks are allowed.
    localparam int BREACT = 2 * TICK_CYCLES + 6;
    logic [11:0] mask_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) mask_q <= 12'hFFF;
        else if (wr && addr == 8'h1C) mask_q <= wdata[11:0];
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
        else $error("Read data not zero outside the answer cycle.");
    a_act_on_evt: assert property (
        $rose(cold_load_active) && mask_q[4] |-> ##[1:8] evt_valid && evt_id == 3'h4 && evt_on)
        else $error("Activation ON event missing.");
    a_act_off_evt: assert property (
        $fell(cold_load_active) && mask_q[10] |-> ##[1:8] evt_valid && evt_id == 3'h4 && !evt_on)
        else $error("Activation OFF event missing.");
    a_blk_excl: assert property (!(blocked && cold_load_active))
        else $error("Blocked and active together.");
    a_act_low: assert property ($rose(cold_load_active) |->
        $past(i_l1, 2) < 16'h0014 && $past(i_l2, 2) < 16'h0014 && $past(i_l3, 2) < 16'h0014)
        else $error("Activation without low current.");
    a_over_rel: assert property (
        cold_load_active && i_l1 > 16'h00C8 |-> ##[1:REACT] !cold_load_active)
        else $error("Overcurrent did not release.");
    a_block_rel: assert property (
        cold_load_active && block_in |-> ##[1:BREACT] !cold_load_active)
        else $error("Blocking did not release.");
    a_evt_time: assert property (evt_valid |-> evt_time % 5 == 0)
        else $error("Event time off the tick grid.");
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// Directed bench for the cold load supervisor with register and timing checks.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TC = 20;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [1:0]  lvl = 2'h1;
    logic        blk = 1'b0;
    logic [31:0] d;
    wire  [15:0] i_l1, i_l2, i_l3;
    wire  [31:0] rdata, evt_time;
    wire  [2:0]  evt_id;
    wire         block_in, cold_load_active, blocked, evt_valid, evt_on;
    int          mismatches = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          act_on = 0;
    int          n;
    logic [7:0]  ra [9] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h24, 8'h28};
    logic [31:0] rv [9] = '{32'h14, 32'h78, 32'hC8, 32'h7D0, 32'h1770, 32'h8, 32'hFFF,
                            32'h0, 32'h0};
    always #25 clock = ~clock;
    cls_feed i_cls_feed (.clock(clock), .rst_n(rst_n), .lvl(lvl), .blk(blk), .i_l1(i_l1),
        .i_l2(i_l2), .i_l3(i_l3), .block_in(block_in));
    cls_supervisor #(.TICK_CYCLES(TC)) i_cls_supervisor (.clock(clock), .rst_n(rst_n),
        .i_l1(i_l1), .i_l2(i_l2), .i_l3(i_l3), .block_in(block_in), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .cold_load_active(cold_load_active),
        .blocked(blocked), .evt_valid(evt_valid), .evt_id(evt_id), .evt_on(evt_on),
        .evt_time(evt_time));
    task automatic wrap_up();
        $display("Mismatches %0d, comparisons %0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            mismatches++;
            $display("[FAIL] %0t took %0d cycles, wanted %0d to %0d", $time, got, lo, hi);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_get(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd_get(a, v);
        check(v, exp);
    endtask
    task automatic set_lvl(input logic [1:0] l);
        @(posedge clock);
        lvl <= l;
    endtask
    // Waits are bounded so a stuck output ends in a range mismatch, not a hang, except in settle, which checks no range.
    task automatic wait_act(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (cold_load_active !== v && cnt < lim) begin
            @(posedge clock);
            #1 cnt++;
        end
    endtask
    task automatic activate();
        set_lvl(2'h0);
        wait_act(1'b1, 8 * TC, n);
        check_rng(n, 4 * TC - 4, 5 * TC + 6);
    endtask
    task automatic settle();
        set_lvl(2'h1);
        wait_act(1'b0, 12 * TC, n);
        repeat (4 * TC) @(posedge clock);
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (evt_valid === 1'b1 && evt_id === 3'h4 && evt_on === 1'b1) begin
            act_on <= act_on + 1;
        end
        if (cycles == 20000) begin
            mismatches++;
            $display("[FAIL] %0t run timed out", $time);
            wrap_up();
        end
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        for (int k = 0; k < 9; k++) rd_chk(ra[k], rv[k]);
        wr_reg(8'hFC, 32'h0000FFFF);
        rd_chk(8'hFC, 32'h0);
        wr_reg(8'h10, 32'h4);
        wr_reg(8'h14, 32'h6);
        wr_reg(8'h18, 32'h3);
        activate();
        set_lvl(2'h1);
        wait_act(1'b0, 8 * TC, n);
        check_rng(n, 3 * TC - 6, 4 * TC + 6);
        settle();
        activate();
        set_lvl(2'h2);
        wait_act(1'b0, 12 * TC, n);
        check_rng(n, 6 * TC, 8 * TC + 6);
        settle();
        activate();
        set_lvl(2'h2);
        repeat (3 * TC) @(posedge clock);
        #1 check({31'h0, cold_load_active}, 32'h1);
        set_lvl(2'h1);
        wait_act(1'b0, 4 * TC, n);
        check_rng(n, 0, 2 * TC + 6);
        settle();
        activate();
        set_lvl(2'h3);
        wait_act(1'b0, 2 * TC, n);
        check_rng(n, 0, TC + 6);
        settle();
        activate();
        @(posedge clock);
        blk <= 1'b1;
        wait_act(1'b0, 3 * TC, n);
        check_rng(n, 0, 2 * TC + 8);
        settle();
        set_lvl(2'h0);
        repeat (7 * TC) @(posedge clock);
        #1 check({30'h0, blocked, cold_load_active}, 32'h2);
        set_lvl(2'h1);
        repeat (3 * TC) @(posedge clock);
        #1 check({31'h0, blocked}, 32'h0);
        @(posedge clock);
        blk <= 1'b0;
        wr_reg(8'h1C, 32'hFEF);
        wr_reg(8'h10, 32'h0);
        set_lvl(2'h0);
        wait_act(1'b1, 3 * TC, n);
        check_rng(n, 0, TC + 6);
        settle();
        wr_reg(8'h1C, 32'hFFF);
        check(act_on, 32'h5);
        rd_chk(8'h24, 32'h6);
        rd_chk(8'h28, 32'h1);
        rd_get(8'h20, d);
        check({28'h0, d[15:12]}, 32'hC);
        wr_reg(8'h00, 32'h3);
        rd_chk(8'h24, 32'h0);
        rd_chk(8'h28, 32'h0);
        // The newest record is the load-normal ON of the last settle, taken at level one.
        wr_reg(8'h2C, 32'h01);
        rd_chk(8'h30, 32'h2);
        wr_reg(8'h2C, 32'h02);
        rd_chk(8'h30, 32'h50);
        wrap_up();
    end
endmodule
bind cls_supervisor cls_supervisor_properties #(.TW(TW), .TICK_CYCLES(TICK_CYCLES)) i_props (
    .clock(clock), .rst_n(rst_n), .i_l1(i_l1), .i_l2(i_l2), .i_l3(i_l3),
    .block_in(block_in), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .cold_load_active(cold_load_active), .blocked(blocked), .evt_valid(evt_valid),
    .evt_id(evt_id), .evt_on(evt_on), .evt_time(evt_time));
`default_nettype wire
